// ==== design/bbc_top.sv ====
// baseband control register bank with axi4-lite slave and pin polarity
// How it works
// - 7-bit register number, lowest address bit unused
// - register 62 selects bank for 66-7e
// - writing gain index loads gain data
// - 32-entry gain table, saturating at 7f
// - read-only identity: part and version nibbles
// - polarity bit 7 inverts incoming q
// - polarity bit 6 inverts outgoing q
// - polarity bit 5 inverts transmit clock
// - polarity bit 4 makes tx ready low
// - polarity bit 3 sets tx enable level
// - polarity bit 2 makes cca active high
// - polarity bit 1 makes rx ready low
// - polarity bit 0 inverts receive clock
// - i cover code at 04, nominal 48
// - q cover code at 06, nominal 48
// - second bank shows rx header fields
// - first bank shows noise and gain error
`default_nettype none
`include "bbc_regs.svh"
module bbc_top #(
  parameter int IQ_W = 6,
  parameter logic [3:0] PART_CODE = 4'h5,    // arbitrary value
  parameter logic [3:0] VERSION_CODE = 4'ha  // arbitrary value
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration and readback with the modem datapath
  output bbc_pkg::bbc_cfg_t cfg,
  input wire logic [7:0] test_bus,
  input wire bbc_pkg::bbc_bank_a_t bank_a,
  input wire bbc_pkg::bbc_bank_b_t bank_b,
  // quadrature samples
  input wire logic [IQ_W-1:0] rx_q_in,
  output logic [IQ_W-1:0] rx_q_core,
  input wire logic [IQ_W-1:0] tx_q_core,
  output logic [IQ_W-1:0] tx_q_out,
  // core-side control levels, active high
  input wire logic tx_clk_core,
  input wire logic tx_ready_core,
  input wire logic cca_core,
  input wire logic rx_ready_core,
  input wire logic rx_clk_core,
  output logic tx_enable_core,
  output logic rx_enable_core,
  // device pins
  input wire logic transmit_enable_in,
  input wire logic receive_enable_in,
  output logic transmit_clock_out,
  output logic transmit_ready_out,
  output logic clear_channel_out,
  output logic receive_data_ready_out,
  output logic receive_clock_out
);

  // ----------------------------------------------------------------
  // gain lookup table
  // ----------------------------------------------------------------
  function automatic logic [7:0] gain_entry(input logic [`BBC_GAIN_IDX_W-1:0] idx);
    logic [7:0] v;
    v = 8'h7f;
    case (idx)
      5'h00: v = 8'h0c;
      5'h01: v = 8'h10;
      5'h02: v = 8'h14;
      5'h03: v = 8'h18;
      5'h04: v = 8'h1c;
      5'h05: v = 8'h20;
      5'h06: v = 8'h24;
      5'h07: v = 8'h28;
      5'h08: v = 8'h2e;
      5'h09: v = 8'h34;
      5'h0a: v = 8'h38;
      5'h0b: v = 8'h3c;
      5'h0c: v = 8'h3f;
      5'h0d: v = 8'h43;
      5'h0e: v = 8'h46;
      5'h0f: v = 8'h48;
      5'h10: v = 8'h46;
      5'h11: v = 8'h50;
      5'h12: v = 8'h55;
      5'h13: v = 8'h5a;
      5'h14: v = 8'h63;
      5'h15: v = 8'h6d;
      5'h16: v = 8'h76;
      default: v = 8'h7f;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // bit 0 of the printed offset is unused, so odd offsets alias
  function automatic logic [7:0] reg_off(input logic [31:0] a);
    return {a[`BBC_ADDR_MSB:`BBC_ADDR_LSB+1], 1'b0};
  endfunction

  function automatic logic in_range(input logic [31:0] a);
    return a[31:`BBC_ADDR_MSB+1] == '0;
  endfunction

  function automatic logic is_ro(input logic [7:0] off);
    return off == `BBC_OFF_ID || off >= `BBC_OFF_TEST_BUS;
  endfunction

  function automatic logic is_rw(input logic [7:0] off);
    logic r;
    r = 1'b0;
    case (off)
      `BBC_OFF_POLARITY, `BBC_OFF_I_COVER, `BBC_OFF_Q_COVER: r = 1'b1;
      `BBC_OFF_GAIN_IDX, `BBC_OFF_GAIN_DATA: r = 1'b1;
      default: r = off >= `BBC_OFF_ANT_THR && off <= `BBC_OFF_BANK_SEL;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  logic aw_hold_q;
  logic w_hold_q;
  logic [31:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_write;
  logic [7:0] woff;
  logic wok;

  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ~w_hold_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign do_write = aw_hold_q & w_hold_q;
  assign woff = reg_off(awaddr_q);
  assign wok = in_range(awaddr_q) & (is_rw(woff) | is_ro(woff));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= 32'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      w_hold_q <= 1'b0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      wbyte_q <= s_axi_wdata[7:0];
      wlane_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_q <= 1'b0;
      bresp_q <= `BBC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wok ? `BBC_RESP_OKAY : `BBC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  bbc_pkg::bbc_cfg_t cfg_q;
  logic wr_en;

  // read-only offsets fall through every branch below untouched
  assign wr_en = do_write & wlane_q & in_range(awaddr_q) & is_rw(woff);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q.polarity <= `BBC_RST_POLARITY;
      cfg_q.i_cover <= `BBC_RST_COVER;
      cfg_q.q_cover <= `BBC_RST_COVER;
      cfg_q.gain_index <= `BBC_RST_GAIN_IDX;
      cfg_q.gain_data <= `BBC_RST_GAIN_DATA;
      cfg_q.ant_thr <= `BBC_RST_ANT_THR;
      cfg_q.pre_lead <= `BBC_RST_PRE_LOOP;
      cfg_q.pre_lag <= `BBC_RST_PRE_LOOP;
      cfg_q.hdr_lead <= `BBC_RST_HDR_LOOP;
      cfg_q.hdr_lag <= `BBC_RST_HDR_LOOP;
      cfg_q.dat_lead <= `BBC_RST_HDR_LOOP;
      cfg_q.dat_lag <= `BBC_RST_HDR_LOOP;
      cfg_q.rf_atten <= `BBC_RST_RF_ATTEN;
      cfg_q.ed_ctrl <= `BBC_RST_ED_CTRL;
      cfg_q.bank_sel <= `BBC_RST_BANK_SEL;
    end else if (wr_en) begin
      case (woff)
        `BBC_OFF_POLARITY: cfg_q.polarity <= wbyte_q;
        `BBC_OFF_I_COVER: cfg_q.i_cover <= wbyte_q;
        `BBC_OFF_Q_COVER: cfg_q.q_cover <= wbyte_q;
        `BBC_OFF_GAIN_IDX: begin
          cfg_q.gain_index <= wbyte_q;
          cfg_q.gain_data <= gain_entry(wbyte_q[`BBC_GAIN_IDX_W-1:0]);
        end
        `BBC_OFF_GAIN_DATA: cfg_q.gain_data <= wbyte_q;
        `BBC_OFF_ANT_THR: cfg_q.ant_thr <= wbyte_q;
        `BBC_OFF_PRE_LEAD: cfg_q.pre_lead <= wbyte_q;
        `BBC_OFF_PRE_LAG: cfg_q.pre_lag <= wbyte_q;
        `BBC_OFF_HDR_LEAD: cfg_q.hdr_lead <= wbyte_q;
        `BBC_OFF_HDR_LAG: cfg_q.hdr_lag <= wbyte_q;
        `BBC_OFF_DAT_LEAD: cfg_q.dat_lead <= wbyte_q;
        `BBC_OFF_DAT_LAG: cfg_q.dat_lag <= wbyte_q;
        `BBC_OFF_RF_ATTEN: cfg_q.rf_atten <= wbyte_q;
        `BBC_OFF_ED_CTRL: cfg_q.ed_ctrl <= wbyte_q;
        `BBC_OFF_BANK_SEL: cfg_q.bank_sel <= wbyte_q;
        default: cfg_q.bank_sel <= cfg_q.bank_sel;
      endcase
    end
  end

  assign cfg = cfg_q;

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic rvalid_q;
  logic [7:0] rbyte_q;
  logic [1:0] rresp_q;
  logic [7:0] roff;
  logic [7:0] rd_byte;
  logic rd_ok;
  logic bank_b_sel;

  assign roff = reg_off(s_axi_araddr);
  assign bank_b_sel = cfg_q.bank_sel[`BBC_BANK_BIT];
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = {24'h000000, rbyte_q};

  always_comb begin
    rd_ok = in_range(s_axi_araddr) & (is_rw(roff) | is_ro(roff));
    rd_byte = 8'h00;
    case (roff)
      `BBC_OFF_ID: rd_byte = {PART_CODE, VERSION_CODE};
      `BBC_OFF_POLARITY: rd_byte = cfg_q.polarity;
      `BBC_OFF_I_COVER: rd_byte = cfg_q.i_cover;
      `BBC_OFF_Q_COVER: rd_byte = cfg_q.q_cover;
      `BBC_OFF_GAIN_IDX: rd_byte = cfg_q.gain_index;
      `BBC_OFF_GAIN_DATA: rd_byte = cfg_q.gain_data;
      `BBC_OFF_ANT_THR: rd_byte = cfg_q.ant_thr;
      `BBC_OFF_PRE_LEAD: rd_byte = cfg_q.pre_lead;
      `BBC_OFF_PRE_LAG: rd_byte = cfg_q.pre_lag;
      `BBC_OFF_HDR_LEAD: rd_byte = cfg_q.hdr_lead;
      `BBC_OFF_HDR_LAG: rd_byte = cfg_q.hdr_lag;
      `BBC_OFF_DAT_LEAD: rd_byte = cfg_q.dat_lead;
      `BBC_OFF_DAT_LAG: rd_byte = cfg_q.dat_lag;
      `BBC_OFF_RF_ATTEN: rd_byte = cfg_q.rf_atten;
      `BBC_OFF_ED_CTRL: rd_byte = cfg_q.ed_ctrl;
      `BBC_OFF_BANK_SEL: rd_byte = cfg_q.bank_sel;
      `BBC_OFF_TEST_BUS: rd_byte = test_bus;
      // first bank holds only three live bytes, the rest read zero
      `BBC_OFF_RO51: rd_byte = bank_b_sel ? bank_b.quality : bank_a.noise_a;
      `BBC_OFF_RO52: rd_byte = bank_b_sel ? bank_b.signal_fld : bank_a.noise_b;
      `BBC_OFF_RO53: rd_byte = bank_b_sel ? bank_b.service_fld : bank_a.gain_err;
      `BBC_OFF_LEN_LO: rd_byte = bank_b_sel ? bank_b.len_lo : 8'h00;
      `BBC_OFF_LEN_HI: rd_byte = bank_b_sel ? bank_b.len_hi : 8'h00;
      `BBC_OFF_CRC_LO: rd_byte = bank_b_sel ? bank_b.crc_lo : 8'h00;
      `BBC_OFF_CRC_HI: rd_byte = bank_b_sel ? bank_b.crc_hi : 8'h00;
      `BBC_OFF_TX_PWR: rd_byte = bank_b_sel ? bank_b.tx_power : 8'h00;
      `BBC_OFF_MEAN_PWR: rd_byte = bank_b_sel ? bank_b.mean_power : 8'h00;
      `BBC_OFF_IF_GAIN: rd_byte = bank_b_sel ? bank_b.if_gain : 8'h00;
      `BBC_OFF_STATUS1: rd_byte = bank_b_sel ? bank_b.status_first : 8'h00;
      `BBC_OFF_RSSI: rd_byte = bank_b_sel ? bank_b.rssi : 8'h00;
      `BBC_OFF_STATUS2: rd_byte = bank_b_sel ? bank_b.status_second : 8'h00;
      default: rd_byte = 8'h00;
    endcase
    if (!rd_ok) begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rbyte_q <= 8'h00;
      rresp_q <= `BBC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rbyte_q <= rd_byte;
      rresp_q <= rd_ok ? `BBC_RESP_OKAY : `BBC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] tx_en_sync_q;
  logic [1:0] rx_en_sync_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_en_sync_q <= 2'b00;
      rx_en_sync_q <= 2'b00;
    end else begin
      tx_en_sync_q <= {tx_en_sync_q[0], transmit_enable_in};
      rx_en_sync_q <= {rx_en_sync_q[0], receive_enable_in};
    end
  end

  // ----------------------------------------------------------------
  // polarity stage
  // ----------------------------------------------------------------
  logic [7:0] pol;
  logic tx_enable_q;
  logic rx_enable_q;
  logic [IQ_W-1:0] rx_q_q;
  logic [IQ_W-1:0] tx_q_q;
  logic tx_clk_q;
  logic tx_rdy_q;
  logic cca_q;
  logic rx_rdy_q;
  logic rx_clk_q;

  assign pol = cfg_q.polarity;

  // negation of the most negative code wraps to itself
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_q_q <= '0;
      tx_q_q <= '0;
    end else begin
      rx_q_q <= pol[`BBC_POL_RX_Q] ? IQ_W'(~rx_q_in + 1'b1) : rx_q_in;
      tx_q_q <= pol[`BBC_POL_TX_Q] ? IQ_W'(~tx_q_core + 1'b1) : tx_q_core;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_enable_q <= 1'b0;
      rx_enable_q <= 1'b0;
    end else begin
      tx_enable_q <= tx_en_sync_q[1] ^ pol[`BBC_POL_TX_EN];
      rx_enable_q <= rx_en_sync_q[1];
    end
  end

  // outputs are registered; clocks thus lag the core by one cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_clk_q <= 1'b0;
      tx_rdy_q <= 1'b0;
      cca_q <= 1'b1;
      rx_rdy_q <= 1'b0;
      rx_clk_q <= 1'b0;
    end else begin
      tx_clk_q <= tx_clk_core ^ pol[`BBC_POL_TX_CLK];
      tx_rdy_q <= tx_ready_core ^ pol[`BBC_POL_TX_RDY];
      cca_q <= cca_core ~^ pol[`BBC_POL_CCA];
      rx_rdy_q <= rx_ready_core ^ pol[`BBC_POL_RX_RDY];
      rx_clk_q <= rx_clk_core ^ pol[`BBC_POL_RX_CLK];
    end
  end

  assign rx_q_core = rx_q_q;
  assign tx_q_out = tx_q_q;
  assign tx_enable_core = tx_enable_q;
  assign rx_enable_core = rx_enable_q;
  assign transmit_clock_out = tx_clk_q;
  assign transmit_ready_out = tx_rdy_q;
  assign clear_channel_out = cca_q;
  assign receive_data_ready_out = rx_rdy_q;
  assign receive_clock_out = rx_clk_q;

endmodule
`default_nettype wire

// ==== design/bbc_regs.svh ====
// register offsets, reset values and field positions of the baseband control bank
`ifndef BBC_REGS_SVH
`define BBC_REGS_SVH
// ----------------------------------------------------------------
// printed offsets, byte address on the bus is four times these
// ----------------------------------------------------------------
`define BBC_OFF_ID 8'h00
`define BBC_OFF_POLARITY 8'h02
`define BBC_OFF_I_COVER 8'h04
`define BBC_OFF_Q_COVER 8'h06
`define BBC_OFF_GAIN_IDX 8'h2c
`define BBC_OFF_GAIN_DATA 8'h2e
`define BBC_OFF_ANT_THR 8'h50
`define BBC_OFF_PRE_LEAD 8'h52
`define BBC_OFF_PRE_LAG 8'h54
`define BBC_OFF_HDR_LEAD 8'h56
`define BBC_OFF_HDR_LAG 8'h58
`define BBC_OFF_DAT_LEAD 8'h5a
`define BBC_OFF_DAT_LAG 8'h5c
`define BBC_OFF_RF_ATTEN 8'h5e
`define BBC_OFF_ED_CTRL 8'h60
`define BBC_OFF_BANK_SEL 8'h62
`define BBC_OFF_TEST_BUS 8'h64
`define BBC_OFF_RO51 8'h66
`define BBC_OFF_RO52 8'h68
`define BBC_OFF_RO53 8'h6a
`define BBC_OFF_LEN_LO 8'h6c
`define BBC_OFF_LEN_HI 8'h6e
`define BBC_OFF_CRC_LO 8'h70
`define BBC_OFF_CRC_HI 8'h72
`define BBC_OFF_TX_PWR 8'h74
`define BBC_OFF_MEAN_PWR 8'h76
`define BBC_OFF_IF_GAIN 8'h78
`define BBC_OFF_STATUS1 8'h7a
`define BBC_OFF_RSSI 8'h7c
`define BBC_OFF_STATUS2 8'h7e
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BBC_RST_POLARITY 8'h00
`define BBC_RST_COVER 8'h48
`define BBC_RST_ANT_THR 8'h0f
`define BBC_RST_PRE_LOOP 8'h20
`define BBC_RST_HDR_LOOP 8'h10
`define BBC_RST_RF_ATTEN 8'h1e
`define BBC_RST_ED_CTRL 8'h1a
`define BBC_RST_BANK_SEL 8'h00
`define BBC_RST_GAIN_IDX 8'h00
`define BBC_RST_GAIN_DATA 8'h0c
// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define BBC_POL_RX_Q 7
`define BBC_POL_TX_Q 6
`define BBC_POL_TX_CLK 5
`define BBC_POL_TX_RDY 4
`define BBC_POL_TX_EN 3
`define BBC_POL_CCA 2
`define BBC_POL_RX_RDY 1
`define BBC_POL_RX_CLK 0
`define BBC_BANK_BIT 0
`define BBC_GAIN_IDX_W 5
`define BBC_ADDR_LSB 2
`define BBC_ADDR_MSB 9
`define BBC_RESP_OKAY 2'b00
`define BBC_RESP_SLVERR 2'b10
`endif

// ==== design/bbc_pkg.sv ====
// types shared by the baseband control register bank
`default_nettype none
package bbc_pkg;
  // configuration handed to the modem datapath
  typedef struct packed {
    logic [7:0] polarity;
    logic [7:0] i_cover;
    logic [7:0] q_cover;
    logic [7:0] gain_index;
    logic [7:0] gain_data;
    logic [7:0] ant_thr;
    logic [7:0] pre_lead;
    logic [7:0] pre_lag;
    logic [7:0] hdr_lead;
    logic [7:0] hdr_lag;
    logic [7:0] dat_lead;
    logic [7:0] dat_lag;
    logic [7:0] rf_atten;
    logic [7:0] ed_ctrl;
    logic [7:0] bank_sel;
  } bbc_cfg_t;
  // first readback bank
  typedef struct packed {
    logic [7:0] noise_a;
    logic [7:0] noise_b;
    logic [7:0] gain_err;
  } bbc_bank_a_t;
  // second readback bank
  typedef struct packed {
    logic [7:0] quality;
    logic [7:0] signal_fld;
    logic [7:0] service_fld;
    logic [7:0] len_lo;
    logic [7:0] len_hi;
    logic [7:0] crc_lo;
    logic [7:0] crc_hi;
    logic [7:0] tx_power;
    logic [7:0] mean_power;
    logic [7:0] if_gain;
    logic [7:0] status_first;
    logic [7:0] rssi;
    logic [7:0] status_second;
  } bbc_bank_b_t;
endpackage
`default_nettype wire

// ==== verification/bbc_monitor.sv ====
// checker for pin polarity and bus timing
`default_nettype none
module bbc_monitor #(
  parameter int IQ_W = 6
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // write handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  // datapath
  input wire bbc_pkg::bbc_cfg_t cfg,
  input wire logic [IQ_W-1:0] rx_q_in,
  input wire logic [IQ_W-1:0] rx_q_core,
  input wire logic [IQ_W-1:0] tx_q_core,
  input wire logic [IQ_W-1:0] tx_q_out,
  input wire logic tx_clk_core,
  input wire logic tx_ready_core,
  input wire logic cca_core,
  input wire logic rx_ready_core,
  input wire logic rx_clk_core,
  input wire logic tx_enable_core,
  input wire logic rx_enable_core,
  // pins
  input wire logic transmit_enable_in,
  input wire logic receive_enable_in,
  input wire logic transmit_clock_out,
  input wire logic transmit_ready_out,
  input wire logic clear_channel_out,
  input wire logic receive_data_ready_out,
  input wire logic receive_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // history guard
  // ------
  // $past must not reach back into reset
  logic [1:0] up_q;
  logic up;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      up_q <= 2'd0;
    end else if (up_q != 2'd3) begin
      up_q <= up_q + 2'd1;
    end
  end
  assign up = (up_q == 2'd3);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ------
  // properties
  // ------
  sequence s_wboth;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_bresp;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  property p_wresp;
    s_wboth |=> s_bresp;
  endproperty
  a_wresp: assert property (p_wresp) else $error("write answer late");
  property p_rxq;
    up |-> rx_q_core == ($past(cfg.polarity[7]) ? -$past(rx_q_in) : $past(rx_q_in));
  endproperty
  a_rxq: assert property (p_rxq) else $error("rx q sense wrong");
  property p_txq;
    up |-> tx_q_out == ($past(cfg.polarity[6]) ? -$past(tx_q_core) : $past(tx_q_core));
  endproperty
  a_txq: assert property (p_txq) else $error("tx q sense wrong");
  property p_transmit_clock_out;
    up |-> transmit_clock_out == ($past(tx_clk_core) ^ $past(cfg.polarity[5]));
  endproperty
  a_transmit_clock_out: assert property (p_transmit_clock_out) else $error("tx clock phase wrong");
  property p_txrdy;
    up |-> transmit_ready_out == ($past(tx_ready_core) ^ $past(cfg.polarity[4]));
  endproperty
  a_txrdy: assert property (p_txrdy) else $error("tx ready level wrong");
  property p_txen;
    up |-> tx_enable_core == ($past(transmit_enable_in, 3) ^ $past(cfg.polarity[3]));
  endproperty
  a_txen: assert property (p_txen) else $error("tx enable level wrong");
  property p_cca;
    up |-> clear_channel_out == !($past(cca_core) ^ $past(cfg.polarity[2]));
  endproperty
  a_cca: assert property (p_cca) else $error("cca level wrong");
  property p_rxrdy;
    up |-> receive_data_ready_out == ($past(rx_ready_core) ^ $past(cfg.polarity[1]));
  endproperty
  a_rxrdy: assert property (p_rxrdy) else $error("rx ready level wrong");
  property p_rxclk;
    up |-> receive_clock_out == ($past(rx_clk_core) ^ $past(cfg.polarity[0]));
  endproperty
  a_rxclk: assert property (p_rxclk) else $error("rx clock phase wrong");
  property p_rxen;
    up |-> rx_enable_core == $past(receive_enable_in, 3);
  endproperty
  a_rxen: assert property (p_rxen) else $error("rx enable wrong");
endmodule
bind bbc_top bbc_monitor #(.IQ_W(IQ_W)) mon_u (.sys_clk, .nrst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .cfg, .rx_q_in, .rx_q_core,
  .tx_q_core, .tx_q_out, .tx_clk_core, .tx_ready_core, .cca_core, .rx_ready_core,
  .rx_clk_core, .tx_enable_core, .rx_enable_core, .transmit_enable_in, .receive_enable_in,
  .transmit_clock_out, .transmit_ready_out, .clear_channel_out, .receive_data_ready_out,
  .receive_clock_out);
`default_nettype wire

// ==== verification/bbc_core_model.sv ====
// modem core stand-in: readback contents and core-side levels
`default_nettype none
module bbc_core_model #(
  parameter int IQ_W = 6
) (
  // clock and reload request
  input wire logic sys_clk,
  input wire logic shuffle,
  // readback contents
  output logic [7:0] test_bus,
  output bbc_pkg::bbc_bank_a_t bank_a,
  output bbc_pkg::bbc_bank_b_t bank_b,
  // samples and levels
  output logic [IQ_W-1:0] rx_q_in,
  output logic [IQ_W-1:0] tx_q_core,
  output logic tx_clk_core,
  output logic tx_ready_core,
  output logic cca_core,
  output logic rx_ready_core,
  output logic rx_clk_core
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge sys_clk) begin
    rx_q_in <= IQ_W'($urandom);
    tx_q_core <= IQ_W'($urandom);
    {tx_clk_core, tx_ready_core, cca_core, rx_ready_core, rx_clk_core} <= 5'($urandom);
    if (shuffle) begin
      test_bus <= 8'($urandom);
      bank_a <= 24'($urandom);
      bank_b <= 104'({$urandom, $urandom, $urandom, $urandom});
    end
  end
endmodule
`default_nettype wire

// ==== verification/bbc_top_bench.sv ====
// self-checking bench for the control register bank
`default_nettype none
module bbc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IQ_W = 6;
  localparam logic [1:0] OK = 2'b00, ER = 2'b10;
  // offset and reset value of every writable register
  localparam logic [15:0] RV [15] = '{16'h0200, 16'h0448, 16'h0648, 16'h2c00, 16'h2e0c,
    16'h500f, 16'h5220, 16'h5420, 16'h5610, 16'h5810, 16'h5a10, 16'h5c10, 16'h5e1e,
    16'h601a, 16'h6200};
  localparam logic [7:0] GT [23] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24,
    8'h28, 8'h2e, 8'h34, 8'h38, 8'h3c, 8'h3f, 8'h43, 8'h46, 8'h48, 8'h46, 8'h50, 8'h55,
    8'h5a, 8'h63, 8'h6d, 8'h76};
  logic sys_clk = 1'b0, nrst = 1'b0, shuffle = 1'b0, pins_on = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  bbc_pkg::bbc_cfg_t cfg;
  bbc_pkg::bbc_bank_a_t bank_a;
  bbc_pkg::bbc_bank_b_t bank_b;
  logic [7:0] test_bus;
  logic [IQ_W-1:0] rx_q_in, rx_q_core, tx_q_core, tx_q_out;
  logic tx_clk_core, tx_ready_core, cca_core, rx_ready_core, rx_clk_core;
  logic tx_enable_core, rx_enable_core;
  logic transmit_enable_in = 1'b0, receive_enable_in = 1'b0;
  logic transmit_clock_out, transmit_ready_out, clear_channel_out;
  logic receive_data_ready_out, receive_clock_out;
  int n_fail = 0, num_checks = 0, cyc = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  // arbitrary part and version codes
  bbc_top #(.IQ_W(IQ_W), .PART_CODE(4'h3), .VERSION_CODE(4'hc)) dut_u (.sys_clk, .nrst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg, .test_bus,
    .bank_a, .bank_b, .rx_q_in, .rx_q_core, .tx_q_core, .tx_q_out, .tx_clk_core,
    .tx_ready_core, .cca_core, .rx_ready_core, .rx_clk_core, .tx_enable_core, .rx_enable_core,
    .transmit_enable_in, .receive_enable_in, .transmit_clock_out, .transmit_ready_out,
    .clear_channel_out, .receive_data_ready_out, .receive_clock_out);
  bbc_core_model #(.IQ_W(IQ_W)) core_u (.sys_clk, .shuffle, .test_bus, .bank_a, .bank_b,
    .rx_q_in, .tx_q_core, .tx_clk_core, .tx_ready_core, .cca_core, .rx_ready_core,
    .rx_clk_core);
  // ------
  // bus tasks and checking
  // ------
  always #2 sys_clk = ~sys_clk;
  function automatic logic [31:0] ad(input logic [7:0] o);
    return {22'h0, o, 2'b00};
  endfunction
  // readback as the core model presents it
  function automatic logic [7:0] bank_exp(input int k, input int i);
    if (i == 0) return test_bus;
    if (k == 0 && i < 4) return bank_a[31-8*i -: 8];
    if (k == 1) return bank_b[111-8*i -: 8];
    return 8'h00;
  endfunction
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge sys_clk); while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r);
    rq.push_back({r, 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
  endtask
  // the oldest note meets each answer
  always @(posedge sys_clk) begin
    if (nrst && s_axi_bvalid) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (nrst && s_axi_rvalid) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (pins_on) begin
      transmit_enable_in <= 1'($urandom);
      receive_enable_in <= 1'($urandom);
    end else transmit_enable_in <= cfg.polarity[3];
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  // ------
  // scenarios
  // ------
  initial begin
    logic [7:0] v;
    int i, k;
    v = 8'($urandom(32'hda0b8d5b));
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rd(ad(8'h00), 8'h3c, OK);
    rd(ad(8'h04) | 32'h4, 8'h48, OK);
    for (i = 0; i < 15; i++) rd(ad(RV[i][15:8]), RV[i][7:0], OK);
    for (i = 0; i < 15; i++) begin
      v = 8'($urandom);
      wr(ad(RV[i][15:8]), v, OK);
      rd(ad(RV[i][15:8]), v, OK);
    end
    for (i = 0; i < 32; i++) begin
      wr(ad(8'h2c), {3'($urandom), 5'(i)}, OK);
      rd(ad(8'h2e), i > 22 ? 8'h7f : GT[i], OK);
    end
    wr(ad(8'h00), 8'hff, OK);
    rd(ad(8'h00), 8'h3c, OK);
    wr(32'h0000_0400, 8'h11, ER);
    rd(32'h0000_0400, 8'h00, ER);
    rd(ad(8'h08), 8'h00, ER);
    for (k = 0; k < 2; k++) begin
      wr(ad(8'h62), 8'(k), OK);
      shuffle <= 1'b1;
      @(posedge sys_clk);
      shuffle <= 1'b0;
      @(posedge sys_clk);
      for (i = 0; i < 14; i++) begin
        v = bank_exp(k, i);
        wr(ad(8'(8'h64 + 2 * i)), ~v, OK);
        rd(ad(8'(8'h64 + 2 * i)), v, OK);
      end
    end
    pins_on <= 1'b1;
    wr(ad(8'h02), 8'hff, OK);
    repeat (40) @(posedge sys_clk);
    wr(ad(8'h02), 8'h00, OK);
    repeat (40) @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rd(ad(8'h60), 8'h1a, OK);
    results();
  end
endmodule
`default_nettype wire
